// File: shared/gpm_pkg.sv
package gpm_pkg;
    localparam int DATA_W = 16;
    localparam int PORT_W = 8;
    localparam int SHARED_W = 46;
    localparam int SET_CNT = 3;
    localparam logic [15:0] PORT_DIR_ADDR = 16'h3400;
    localparam logic [15:0] PORT_DATA_ADDR = 16'h3401;
    localparam logic [15:0] SHARED_BASE_ADDR = 16'h4400;
    localparam logic [15:0] SHARED_LAST_ADDR = 16'h4408;
    localparam logic [15:0] SHARED_STRIDE = 16'h0003;
    localparam logic [1:0] KIND_EN = 2'h0;
    localparam logic [1:0] KIND_DIR = 2'h1;
    localparam logic [1:0] KIND_DAT = 2'h2;
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam logic [7:0] PORT_RESET = 8'h00;
    localparam logic [15:0] SET_FULL_MASK = 16'hFFFF;
    localparam logic [15:0] SET_LAST_MASK = 16'h3FFF;

    // one peripheral bus request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [15:0] wdata;
    } gpm_bus_req_s;

    // shared pins, first member lands in the top bits
    typedef struct packed {
        logic [1:0] hostCtrl;
        logic [7:0] hostData;
        logic [15:0] ctrl;
        logic [15:0] data;
        logic [3:0] addr;
    } gpm_shared_pins_s;

    // decoded shared register select
    typedef struct packed {
        logic hit;
        logic [1:0] set;
        logic [1:0] kind;
    } gpm_sel_s;

    // address to set and register kind
    function automatic gpm_sel_s gpm_decode(input logic [15:0] a);
        gpm_sel_s sel;
        logic [15:0] off;
        logic [15:0] setBase;
        sel = '0;
        off = a - SHARED_BASE_ADDR;
        setBase = 16'h0000;
        if (a >= SHARED_BASE_ADDR && a <= SHARED_LAST_ADDR) begin
            sel.hit = 1'b1;
            if (off >= 2 * SHARED_STRIDE) begin
                sel.set = 2'h2;
                setBase = 16'(2 * SHARED_STRIDE);
            end else if (off >= SHARED_STRIDE) begin
                sel.set = 2'h1;
                setBase = SHARED_STRIDE;
            end
            sel.kind = 2'(off - setBase);
        end
        return sel;
    endfunction

    // valid bits of a set, the last set is partial
    function automatic logic [15:0] gpm_set_mask(input int s);
        return (s == SET_CNT - 1) ? SET_LAST_MASK : SET_FULL_MASK;
    endfunction
endpackage

// File: design/gpm_port.sv
`timescale 1ns/1ps
module gpm_port (
    input wire logic sys_clk,
    input wire logic reset,
    input wire gpm_pkg::gpm_bus_req_s busReq,
    output logic [15:0] rdData,
    output logic rdValid,
    input wire logic [7:0] gpioIn,
    output logic [7:0] gpioOut,
    output logic [7:0] gpioOe,
    input wire logic muxMode,
    input wire gpm_pkg::gpm_shared_pins_s sharedIn,
    output gpm_pkg::gpm_shared_pins_s sharedOut,
    output gpm_pkg::gpm_shared_pins_s sharedOe,
    input wire gpm_pkg::gpm_shared_pins_s altOut,
    input wire gpm_pkg::gpm_shared_pins_s altOe,
    output gpm_pkg::gpm_shared_pins_s altIn
);
    import gpm_pkg::*;

    logic [7:0] portDir_r;
    logic [7:0] portLevel_r;
    logic [15:0] shEn_r [SET_CNT];
    logic [15:0] shDir_r [SET_CNT];
    logic [15:0] shLevel_r [SET_CNT];
    logic [15:0] rdData_r;
    logic rdValid_r;
    logic [15:0] rdData_nxt;
    logic [7:0] gpioOut_r;
    logic [7:0] gpioOe_r;
    gpm_shared_pins_s sharedOut_r;
    gpm_shared_pins_s sharedOe_r;
    gpm_shared_pins_s altIn_r;
    gpm_sel_s sel;
    logic [47:0] pinFlat;
    logic [47:0] enFlat;
    logic [47:0] levelFlat;

    // pin struct packs index n at bit n
    assign pinFlat = {2'b00, sharedIn};
    // register set n/16 bit n%16 serves index n
    assign enFlat = {shEn_r[2], shEn_r[1], shEn_r[0]};
    assign levelFlat = {shLevel_r[2], shLevel_r[1], shLevel_r[0]};
    assign sel = gpm_decode(busReq.addr);

    // dedicated port direction, bits 7..0 only
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            portDir_r <= PORT_RESET;
        end else if (busReq.wr && busReq.addr == PORT_DIR_ADDR) begin
            portDir_r <= busReq.wdata[PORT_W-1:0];
        end
    end

    // dedicated port output latch
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            portLevel_r <= PORT_RESET;
        end else if (busReq.wr && busReq.addr == PORT_DATA_ADDR) begin
            portLevel_r <= busReq.wdata[PORT_W-1:0];
        end
    end

    // shared enable, direction and data sets
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            for (int s = 0; s < SET_CNT; s++) begin
                shEn_r[s] <= REG_RESET;
                shDir_r[s] <= REG_RESET;
                shLevel_r[s] <= REG_RESET;
            end
        end else if (busReq.wr && sel.hit) begin
            for (int s = 0; s < SET_CNT; s++) begin
                if (sel.set == 2'(s)) begin
                    unique case (sel.kind)
                        KIND_EN: shEn_r[s] <= busReq.wdata & gpm_set_mask(s);
                        KIND_DIR: shDir_r[s] <= busReq.wdata & gpm_set_mask(s);
                        KIND_DAT: shLevel_r[s] <= busReq.wdata
                            & gpm_set_mask(s);
                        default: ;
                    endcase
                end
            end
        end
    end

    // read mux, input bits show the live pin
    always_comb begin
        rdData_nxt = 16'h0000;
        if (busReq.addr == PORT_DIR_ADDR) begin
            rdData_nxt = {8'h00, portDir_r}; // upper bits zero
        end else if (busReq.addr == PORT_DATA_ADDR) begin
            rdData_nxt = {8'h00, (portDir_r & portLevel_r)
                | (~portDir_r & gpioIn)};
        end else if (sel.hit) begin
            for (int s = 0; s < SET_CNT; s++) begin
                if (sel.set == 2'(s)) begin
                    unique case (sel.kind)
                        KIND_EN: rdData_nxt = shEn_r[s];
                        KIND_DIR: rdData_nxt = shDir_r[s];
                        KIND_DAT: rdData_nxt = ((shDir_r[s] & shLevel_r[s])
                            | (~shDir_r[s] & pinFlat[s*DATA_W +: DATA_W]))
                            & gpm_set_mask(s);
                        default: rdData_nxt = 16'h0000;
                    endcase
                end
            end
        end
    end

    // registered read answer, one cycle after the strobe
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rdData_r <= 16'h0000;
            rdValid_r <= 1'b0;
        end else begin
            rdValid_r <= busReq.rd;
            rdData_r <= busReq.rd ? rdData_nxt : 16'h0000;
        end
    end

    // dedicated pin drivers follow direction and latch
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            gpioOe_r <= PORT_RESET;
            gpioOut_r <= PORT_RESET;
        end else begin
            gpioOe_r <= portDir_r; // one means output
            gpioOut_r <= portLevel_r;
        end
    end

    // shared pin owner select
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            sharedOe_r <= '0;
            sharedOut_r <= '0;
            altIn_r <= '0;
        end else begin
            altIn_r <= sharedIn;
            if (muxMode) begin
                sharedOe_r <= altOe;
                sharedOut_r <= altOut;
            end else begin
                // enable gates the driver
                sharedOe_r <= enFlat[SHARED_W-1:0];
                sharedOut_r <= levelFlat[SHARED_W-1:0];
            end
        end
    end

    assign rdData = rdData_r;
    assign rdValid = rdValid_r;
    assign gpioOut = gpioOut_r;
    assign gpioOe = gpioOe_r;
    assign sharedOut = sharedOut_r;
    assign sharedOe = sharedOe_r;
    assign altIn = altIn_r;

    // direction reads back with zero upper byte
    a_dir_reserved: assert property (
        @(posedge sys_clk) disable iff (reset)
        busReq.rd && busReq.addr == PORT_DIR_ADDR
        |=> rdValid && rdData[15:8] == 8'h00 && rdData[7:0] == gpioOe)
        else $error("direction readback wrong");

    // direction write reaches the enables two edges on
    a_port_direction: assert property (
        @(posedge sys_clk) disable iff (reset)
        busReq.wr && busReq.addr == PORT_DIR_ADDR
        |=> ##1 gpioOe == $past(busReq.wdata[7:0], 2))
        else $error("port direction not applied");

    // data write reaches the pin drivers
    a_port_drive: assert property (
        @(posedge sys_clk) disable iff (reset)
        busReq.wr && busReq.addr == PORT_DATA_ADDR
        |=> ##1 gpioOut == $past(busReq.wdata[7:0], 2))
        else $error("port data not driven");

    // input bits of the port read the pin level
    a_port_input: assert property (
        @(posedge sys_clk) disable iff (reset)
        busReq.rd && busReq.addr == PORT_DATA_ADDR
        |=> ((rdData[7:0] ^ $past(gpioIn)) & ~$past(portDir_r)) == 8'h00)
        else $error("input pin level not read");

    // interfaces own the pins in mux mode one
    a_mux_owner: assert property (
        @(posedge sys_clk) disable iff (reset)
        muxMode |=> sharedOe == $past(altOe) && sharedOut == $past(altOut))
        else $error("mux mode not honoured");

    // enable zero never drives in general purpose mode
    a_enable_gate: assert property (
        @(posedge sys_clk) disable iff (reset)
        !muxMode |=> (sharedOe & ~$past(enFlat[SHARED_W-1:0])) == '0)
        else $error("disabled shared pin driving");

    // enabled shared pins drive their data bits
    a_shared_drive: assert property (
        @(posedge sys_clk) disable iff (reset)
        !muxMode ##1 !muxMode |=> sharedOe == $past(enFlat[SHARED_W-1:0])
            && sharedOut == $past(levelFlat[SHARED_W-1:0]))
        else $error("shared output wrong");

    // control pin zero sits at index twenty
    a_ctrl_map: assert property (
        @(posedge sys_clk) disable iff (reset)
        busReq.rd && busReq.addr == SHARED_BASE_ADDR + SHARED_STRIDE
            + KIND_DAT && shDir_r[1][4] == 1'b0
        |=> rdData[4] == $past(sharedIn.ctrl[0]))
        else $error("control pin index wrong");

    // host control one lands at index forty-five
    a_host_map: assert property (
        @(posedge sys_clk) disable iff (reset)
        busReq.rd && busReq.addr == SHARED_LAST_ADDR && shDir_r[2][13] == 1'b0
        |=> rdData[13] == $past(sharedIn.hostCtrl[1])
            && rdData[15:14] == 2'b00)
        else $error("host pin index wrong");

    // enable set zero is clear after reset
    a_enable_reset: assert property (
        @(posedge sys_clk) $fell(reset) |-> shEn_r[0] == 16'h0000)
        else $error("enable set not reset");

    // unmapped reads answer zero
    a_unmapped_zero: assert property (
        @(posedge sys_clk) disable iff (reset)
        busReq.rd && !sel.hit && busReq.addr != PORT_DIR_ADDR
            && busReq.addr != PORT_DATA_ADDR
        |=> rdValid && rdData == 16'h0000)
        else $error("unmapped read not zero");

    // no strobe, no answer
    a_rd_idle: assert property (
        @(posedge sys_clk) disable iff (reset)
        !busReq.rd |=> !rdValid && rdData == 16'h0000)
        else $error("answer without read strobe");

    // data register upper byte reads zero
    a_data_upper: assert property (
        @(posedge sys_clk) disable iff (reset)
        busReq.rd && busReq.addr == PORT_DATA_ADDR
        |=> rdValid && rdData[15:8] == 8'h00)
        else $error("data upper byte not zero");

    // output bits of the port read the latch
    a_port_output: assert property (
        @(posedge sys_clk) disable iff (reset)
        busReq.rd && busReq.addr == PORT_DATA_ADDR
        |=> ((rdData[7:0] ^ $past(portLevel_r)) & $past(portDir_r)) == 8'h00)
        else $error("output latch not read");

    // pin drive value moves only on a data write
    a_level_hold: assert property (
        @(posedge sys_clk) disable iff (reset)
        !(busReq.wr && busReq.addr == PORT_DATA_ADDR)
        |=> ##1 $stable(gpioOut))
        else $error("port drive changed unasked");

    // pin enables move only on a direction write
    a_dir_hold: assert property (
        @(posedge sys_clk) disable iff (reset)
        !(busReq.wr && busReq.addr == PORT_DIR_ADDR)
        |=> ##1 $stable(gpioOe))
        else $error("port enable changed unasked");

    // input bits of set zero read the pins
    a_shared_input: assert property (
        @(posedge sys_clk) disable iff (reset)
        busReq.rd && busReq.addr == SHARED_BASE_ADDR + KIND_DAT
        |=> ((rdData ^ $past(pinFlat[DATA_W-1:0])) & ~$past(shDir_r[0]))
            == 16'h0000)
        else $error("shared input level not read");

    // output bits of set two read the latch
    a_shared_latch: assert property (
        @(posedge sys_clk) disable iff (reset)
        busReq.rd && busReq.addr == SHARED_LAST_ADDR
        |=> ((rdData ^ $past(shLevel_r[2])) & $past(shDir_r[2]))
            == 16'h0000)
        else $error("shared latch not read");

    // unused top bits of set two read zero
    a_set2_reserved: assert property (
        @(posedge sys_clk) disable iff (reset)
        busReq.rd && sel.hit && sel.set == 2'h2
        |=> rdData[15:14] == 2'b00)
        else $error("set two top bits not zero");

    // address pin at index zero, data pin at four
    a_addr_map: assert property (
        @(posedge sys_clk) disable iff (reset)
        busReq.rd && busReq.addr == SHARED_BASE_ADDR + KIND_DAT
            && shDir_r[0][0] == 1'b0 && shDir_r[0][4] == 1'b0
        |=> rdData[0] == $past(sharedIn.addr[0])
            && rdData[4] == $past(sharedIn.data[0]))
        else $error("address or data pin index wrong");

    // host data pin zero lands at index thirty-six
    a_host_data_map: assert property (
        @(posedge sys_clk) disable iff (reset)
        busReq.rd && busReq.addr == SHARED_LAST_ADDR && shDir_r[2][4] == 1'b0
        |=> rdData[4] == $past(sharedIn.hostData[0]))
        else $error("host data pin index wrong");

    // interfaces see the pins one cycle late
    a_alt_input: assert property (
        @(posedge sys_clk) disable iff (reset)
        !reset |=> altIn == $past(sharedIn))
        else $error("interface input not passed");

    // no driver on and no answer straight after reset
    a_oe_reset: assert property (
        @(posedge sys_clk) $fell(reset)
        |-> sharedOe == '0 && gpioOe == 8'h00 && rdValid == 1'b0)
        else $error("driver on after reset");

    // unmapped writes leave the port alone
    a_unmapped_write: assert property (
        @(posedge sys_clk) disable iff (reset)
        busReq.wr && !sel.hit && busReq.addr != PORT_DIR_ADDR
            && busReq.addr != PORT_DATA_ADDR
        |=> $stable(portDir_r) && $stable(portLevel_r))
        else $error("unmapped write changed port");

    // enable set zero takes the whole word
    a_en_write: assert property (
        @(posedge sys_clk) disable iff (reset)
        busReq.wr && busReq.addr == SHARED_BASE_ADDR
        |=> shEn_r[0] == $past(busReq.wdata))
        else $error("enable set zero not written");

    // direction set one sits one stride up
    a_dir_write_set: assert property (
        @(posedge sys_clk) disable iff (reset)
        busReq.wr && busReq.addr == SHARED_BASE_ADDR + SHARED_STRIDE + KIND_DIR
        |=> shDir_r[1] == $past(busReq.wdata))
        else $error("direction set one not written");

    // data set two keeps only its valid bits
    a_data_write_set: assert property (
        @(posedge sys_clk) disable iff (reset)
        busReq.wr && busReq.addr == SHARED_LAST_ADDR
        |=> shLevel_r[2] == ($past(busReq.wdata) & SET_LAST_MASK))
        else $error("data set two not written");
endmodule // gpm_port

// File: testbench/gpm_board.sv
`timescale 1ns/1ps
module gpm_board (
    input wire logic [7:0] gpioOut,
    input wire logic [7:0] gpioOe,
    input wire gpm_pkg::gpm_shared_pins_s sharedOut,
    input wire gpm_pkg::gpm_shared_pins_s sharedOe,
    input wire logic [7:0] extPort,
    input wire logic [45:0] extShared,
    output logic [7:0] gpioIn,
    output gpm_pkg::gpm_shared_pins_s sharedIn
);
    import gpm_pkg::*;
    // wire level: a driving device wins, else the board source
    assign gpioIn = (gpioOe & gpioOut) | (~gpioOe & extPort);
    assign sharedIn = (sharedOe & sharedOut)
        | (~sharedOe & extShared);
endmodule // gpm_board

// File: testbench/gpio_and_muxed_pin_port_tb.sv
`timescale 1ns/1ps
module gpio_and_muxed_pin_port_tb;
    import gpm_pkg::*;
    logic sys_clk, reset, muxMode, rdValid;
    gpm_bus_req_s busReq;
    logic [15:0] rdData;
    logic [7:0] gpioIn, gpioOut, gpioOe, extPort;
    gpm_shared_pins_s sharedIn, sharedOut, sharedOe, altOut, altOe, altIn;
    logic [45:0] extShared;
    logic [15:0] pat [3] = '{16'h1E2D, 16'h3C4B, 16'hC5A6};
    int n_errors = 0;
    int comparisons = 0;

    gpm_port dut (.sys_clk(sys_clk), .reset(reset), .busReq(busReq),
        .rdData(rdData), .rdValid(rdValid), .gpioIn(gpioIn),
        .gpioOut(gpioOut), .gpioOe(gpioOe), .muxMode(muxMode),
        .sharedIn(sharedIn), .sharedOut(sharedOut), .sharedOe(sharedOe),
        .altOut(altOut), .altOe(altOe), .altIn(altIn));
    gpm_board board (.gpioOut(gpioOut), .gpioOe(gpioOe),
        .sharedOut(sharedOut), .sharedOe(sharedOe), .extPort(extPort),
        .extShared(extShared), .gpioIn(gpioIn), .sharedIn(sharedIn));

    task automatic report_and_stop();
        if (n_errors == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [45:0] got, input logic [45:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time,
                got, exp);
        end
    endtask

    function automatic logic [15:0] addrOf(input int s, input logic [1:0] k);
        return 16'(SHARED_BASE_ADDR + SHARED_STRIDE * s + k);
    endfunction

    // one write strobe, then an idle cycle
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        busReq = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge sys_clk);
        busReq = '0;
        @(negedge sys_clk);
    endtask

    // one read strobe, answer checked in the following cycle
    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        busReq = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(negedge sys_clk);
        busReq = '0;
        chk(46'(rdValid), 46'h1);
        chk(46'(rdData), 46'(exp));
        @(negedge sys_clk);
    endtask

    // free-running clock
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // hang guard
    initial begin
        #20000;
        n_errors++;
        report_and_stop();
    end

    // main sequence
    initial begin
        reset = 1'b1;
        busReq = '0;
        muxMode = 1'b0;
        extPort = 8'hA5;
        extShared = 46'h2A5A_5A5A_C3C3;
        altOut = '0;
        altOe = '0;
        repeat (5) @(negedge sys_clk);
        reset = 1'b0;
        @(negedge sys_clk);
        rd(PORT_DIR_ADDR, 16'h0000);
        rd(PORT_DATA_ADDR, 16'h00A5);
        wr(PORT_DIR_ADDR, 16'hFFFF);
        rd(PORT_DIR_ADDR, 16'h00FF);
        wr(PORT_DATA_ADDR, 16'h1234);
        chk(46'(gpioOut), 46'h34);
        chk(46'(gpioOe), 46'hFF);
        wr(PORT_DIR_ADDR, 16'h000F);
        rd(PORT_DATA_ADDR, 16'h00A4);
        chk(46'(gpioOe), 46'h0F);
        rd(16'h3402, 16'h0000);
        wr(16'h3402, 16'hFFFF);
        chk(46'(gpioOe), 46'h0F);
        // every set as output, direction before enable
        for (int s = 0; s < 3; s++) begin
            wr(addrOf(s, KIND_DIR), 16'hFFFF);
            wr(addrOf(s, KIND_DAT), pat[s]);
            wr(addrOf(s, KIND_EN), 16'hFFFF);
        end
        chk(sharedOe, {46{1'b1}});
        chk(sharedOut, {pat[2][13:0], pat[1], pat[0]});
        chk(46'(sharedOut.hostCtrl), 46'(pat[2][13:12]));
        rd(addrOf(2, KIND_DAT), pat[2] & 16'h3FFF);
        // set zero back to input, enable first
        wr(addrOf(0, KIND_EN), 16'h0000);
        wr(addrOf(0, KIND_DIR), 16'h0000);
        chk(46'(sharedOe[15:0]), 46'h0);
        rd(addrOf(0, KIND_DAT), extShared[15:0]);
        // interfaces own the pins
        muxMode = 1'b1;
        altOut = 46'h1555_AAAA_5555;
        altOe = 46'h0FFF_0000_FFFF;
        repeat (2) @(negedge sys_clk);
        chk(sharedOut & altOe, altOut & altOe);
        chk(sharedOe, altOe);
        chk(altIn, sharedIn);
        muxMode = 1'b0;
        repeat (2) @(negedge sys_clk);
        chk(46'(sharedOe[45:16]), 46'h3FFF_FFFF);
        // upper sets back to input, read the board levels
        for (int s = 1; s < 3; s++) begin
            wr(addrOf(s, KIND_EN), 16'h0000);
            wr(addrOf(s, KIND_DIR), 16'h0000);
        end
        rd(addrOf(1, KIND_DAT), extShared[31:16]);
        rd(addrOf(2, KIND_DAT), 16'(extShared[45:32]));
        report_and_stop();
    end
endmodule // gpio_and_muxed_pin_port_tb
